/* File: logic/gtm_pkg.sv */
// gtm_pkg: register map, field positions, reset values and timing constants of the gated timer
// assumes a 32-bit avalon-mm slave with word-aligned registers, one clock domain
`default_nettype none
package gtm_pkg;
   localparam int unsigned ADDR_WIDTH = 5;
   // register byte addresses
   localparam logic [4:0] ADDR_TIMER_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_GATE_CONTROL  = 5'h04;
   localparam logic [4:0] ADDR_COUNT_LOW     = 5'h08;
   localparam logic [4:0] ADDR_COUNT_HIGH    = 5'h0C;
   localparam logic [4:0] ADDR_PERIPH_ENABLE = 5'h10;
   localparam logic [4:0] ADDR_PERIPH_FLAGS  = 5'h14;
   localparam logic [4:0] ADDR_INT_CONTROL   = 5'h18;
   // timer_control fields
   localparam int unsigned TC_CS_LSB   = 6;
   localparam int unsigned TC_PS_LSB   = 4;
   localparam int unsigned TC_NOSYNC   = 2;
   localparam int unsigned TC_ON       = 0;
   localparam logic [7:0]  TC_WMASK    = 8'hF5;
   // gate_control fields
   localparam int unsigned GC_GE       = 7;
   localparam int unsigned GC_POL      = 6;
   localparam int unsigned GC_TM       = 5;
   localparam int unsigned GC_SPM      = 4;
   localparam int unsigned GC_GO       = 3;
   localparam int unsigned GC_VAL      = 2;
   localparam int unsigned GC_SS_LSB   = 0;
   localparam logic [7:0]  GC_WMASK    = 8'hF3;
   // enable and flag bit positions
   localparam int unsigned PE_GATE     = 7;
   localparam int unsigned PE_OVF      = 0;
   localparam int unsigned IC_GIE      = 7;
   localparam int unsigned IC_PERIPHERAL_INT_ENABLE     = 6;
   localparam logic [7:0]  PE_WMASK    = 8'h81;
   localparam logic [7:0]  IC_WMASK    = 8'hC0;
   // reset values
   localparam logic [7:0]  TC_RESET    = 8'h00;
   localparam logic [7:0]  GC_RESET    = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
   localparam logic [31:0] UNMAPPED_RD = 32'h00000000;
   // timing
   localparam real         CLK_MHZ          = 200.0;
   localparam int unsigned INSTR_DIV        = 4;
   localparam logic [1:0]  INSTR_DIV_LAST   = 2'(INSTR_DIV - 1);
   localparam real         LFOSC_KHZ        = 31.0;
   localparam int unsigned LFOSC_CYCLES     = int'($floor(CLK_MHZ * 1000.0 / (2.0 * LFOSC_KHZ)));
   localparam int unsigned LFOSC_CNT_W      = 12;

   typedef enum logic [1:0] {
      CS_INSTR, CS_SYS, CS_PIN, CS_LFOSC
   } gtm_clk_src_type;

   typedef enum logic [1:0] {
      GS_PIN, GS_COMPANION, GS_COMPARATOR, GS_RESERVED
   } gtm_gate_src_type;

   typedef struct packed {
      logic externalClockPin;
      logic gatePin;
      logic companionTimerWrapPulse;
      logic comparatorOutputSynced;
   } gtm_pins_type;

   typedef struct packed {
      logic       read;
      logic       write;
      logic [4:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } gtm_bus_req_type;
endpackage
`default_nettype wire

/* File: logic/gtm_timer.sv */
// gtm_timer: 16-bit gated timer/counter with avalon-mm register slave
// assumes pin inputs synchronous to core_clk; sleep indicated by an input level
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - toggle mode routes gate through flip-flop flipping on each rising gate edge.
// - toggle flip-flop forced and held zero while toggle-mode bit is clear.
// - single-pulse set then go bit; counting enabled from next rising gate edge.
// - go bit cleared on trailing edge of pulse; further gate events blocked.
// - toggle and single-pulse together count exactly one full gate cycle.
// - read-only gate-value bit shows current gate level, valid with gating off.
// - falling edge of gate value sets gate-event flag; interrupt if enabled.
// - gate-event flag works even with gate-enable bit clear.
// - counter wraps ffff to 0000 and sets the overflow flag.
// - overflow interrupt needs timer-on, overflow enable, peripheral and global enable.
// - sleep counting only in asynchronous counter mode: pin clock source with no-sync set.
// - overflow in sleep wakes device; vector only if global enable set.
// - clock select 11 lfosc, 10 pin rising edge, 01 system, 00 instruction.
// - prescale 11 by eight, 10 by four, 01 by two, 00 undivided.
// - no-sync one uses pin edge unsynchronised; zero synchronises to system clock.
// - clearing timer-on stops counter and clears gate flip-flops.
// - gate enable ignored when off; on, one gates counting, zero free-runs.
// - gate polarity one counts while gate high, zero while gate low.
// - gate source 00 pin, 01 companion wrap, 10 comparator, 11 reserved.
// - go bit reads one while armed and waiting; hardware clears it.
// - write to a counter byte loads that byte and clears the prescaler.
// - companion timer wrap pulse is one selectable gate source.
module gtm_timer
   import gtm_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  rstn,
   input  wire logic [4:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [3:0]            avs_byteenable,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire gtm_pkg::gtm_pins_type pins,
   input  wire logic                  sleepMode,
   output logic                       overflowIrq,
   output logic                       gateEventIrq,
   output logic                       wakeUp
);
   import gtm_pkg::*;

   logic [7:0]  timerControl;
   logic [7:0]  gateControlW;
   logic        acqGo;
   logic [15:0] count;
   logic [7:0]  periphEnables;
   logic        overflowFlag;
   logic        gateEventFlag;
   logic [7:0]  intControl;
   logic        accepted;
   logic        pinPrev;
   logic        pinSync1;
   logic        pinSync2;
   logic        pinSyncPrev;
   logic [1:0]  instrDiv;
   logic [LFOSC_CNT_W-1:0] lfCnt;
   logic        lfTick;
   logic [2:0]  prescale;
   logic        toggleFf;
   logic        gateRawPrev;
   logic        gateValPrev;
   logic        timerOn;
   logic        sourceTick;
   logic        scaledTick;
   logic        countEnable;
   logic        gateRaw;
   logic        gateValue;
   logic        gateRise;
   logic        gateCondition;
   logic        spmWindow;
   logic        spmArmed;
   logic        inWindow;
   logic        reqValid;
   logic        wrTimerControl;
   logic        wrGateControl;
   logic        wrCountLow;
   logic        wrCountHigh;
   logic        wrPeriph;
   logic        wrFlags;
   logic        wrInt;
   logic        wrLane0;
   logic [7:0]  gateControlRd;
   logic [31:0] next_readdata;

   function automatic logic isWrite(input logic [4:0] a, input logic [4:0] target);
      return reqValid && avs_write && (a == target);
   endfunction

   // one-cycle answer: waitrequest high on request cycle, low on the next
   assign reqValid       = (avs_read || avs_write) && !accepted;
   assign wrLane0        = avs_byteenable[0];
   assign wrTimerControl = isWrite(avs_address, ADDR_TIMER_CONTROL) && wrLane0;
   assign wrGateControl  = isWrite(avs_address, ADDR_GATE_CONTROL) && wrLane0;
   assign wrCountLow     = isWrite(avs_address, ADDR_COUNT_LOW) && wrLane0;
   assign wrCountHigh    = isWrite(avs_address, ADDR_COUNT_HIGH) && wrLane0;
   assign wrPeriph       = isWrite(avs_address, ADDR_PERIPH_ENABLE) && wrLane0;
   assign wrFlags        = isWrite(avs_address, ADDR_PERIPH_FLAGS) && wrLane0;
   assign wrInt          = isWrite(avs_address, ADDR_INT_CONTROL) && wrLane0;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         accepted <= 1'b0;
      end else begin
         accepted <= reqValid;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !reqValid;
      end
   end

   // ---------------- clock source selection ----------------
   assign timerOn = timerControl[TC_ON];

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         instrDiv <= 2'h0;
      end else begin
         instrDiv <= (instrDiv == INSTR_DIV_LAST) ? 2'h0 : instrDiv + 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         lfCnt  <= '0;
         lfTick <= 1'b0;
      end else begin
         lfTick <= (lfCnt == LFOSC_CNT_W'(LFOSC_CYCLES - 1));
         lfCnt  <= (lfCnt == LFOSC_CNT_W'(LFOSC_CYCLES - 1)) ? '0 : lfCnt + 1'b1;
      end
   end

   // pin edge: direct sample when unsynchronised, two-stage synchroniser otherwise
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pinPrev     <= 1'b0;
         pinSync1    <= 1'b0;
         pinSync2    <= 1'b0;
         pinSyncPrev <= 1'b0;
      end else begin
         pinPrev     <= pins.externalClockPin;
         pinSync1    <= pins.externalClockPin;
         pinSync2    <= pinSync1;
         pinSyncPrev <= pinSync2;
      end
   end

   always_comb begin
      unique case (gtm_clk_src_type'(timerControl[TC_CS_LSB +: 2]))
         CS_INSTR: sourceTick = (instrDiv == INSTR_DIV_LAST);
         CS_SYS:   sourceTick = 1'b1;
         CS_PIN:   sourceTick = timerControl[TC_NOSYNC] ?
                                (pins.externalClockPin && !pinPrev) :
                                (pinSync2 && !pinSyncPrev);
         CS_LFOSC: sourceTick = lfTick;
      endcase
   end

   // only asynchronous pin counting survives sleep
   logic sleepOk;
   assign sleepOk = !sleepMode || (timerControl[TC_NOSYNC] &&
                    (timerControl[TC_CS_LSB +: 2] == 2'(CS_PIN)));

   // prescaler: a wrap of the selected low bits releases one count tick
   always_comb begin
      unique case (timerControl[TC_PS_LSB +: 2])
         2'h0:    scaledTick = sourceTick;
         2'h1:    scaledTick = sourceTick && (prescale[0] == 1'b1);
         2'h2:    scaledTick = sourceTick && (prescale[1:0] == 2'h3);
         default: scaledTick = sourceTick && (prescale == 3'h7);
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn || wrCountLow || wrCountHigh) begin
         prescale <= 3'h0;
      end else if (timerOn && sourceTick && sleepOk) begin
         prescale <= prescale + 3'h1;
      end
   end

   // ---------------- gate path ----------------
   always_comb begin
      unique case (gtm_gate_src_type'(gateControlW[GC_SS_LSB +: 2]))
         GS_PIN:        gateRaw = pins.gatePin;
         GS_COMPANION:  gateRaw = pins.companionTimerWrapPulse;
         GS_COMPARATOR: gateRaw = pins.comparatorOutputSynced;
         GS_RESERVED:   gateRaw = 1'b0;
      endcase
   end

   // polarity applied before the toggle so the toggle counts active edges
   logic gatePol;
   assign gatePol  = gateControlW[GC_POL] ? gateRaw : !gateRaw;
   assign gateRise = gatePol && !gateRawPrev;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         gateRawPrev <= 1'b0;
      end else begin
         gateRawPrev <= gatePol;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn || !timerOn || !gateControlW[GC_TM]) begin
         toggleFf <= 1'b0;
      end else if (gateRise) begin
         toggleFf <= !toggleFf;
      end
   end

   assign gateCondition = gateControlW[GC_TM] ? toggleFf : gatePol;

   // single pulse: armed by go, window opens on next rising edge of the condition
   assign spmArmed = gateControlW[GC_SPM] && acqGo;
   logic condPrev;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         condPrev <= 1'b0;
      end else begin
         condPrev <= gateCondition;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn || !spmArmed || !timerOn) begin
         inWindow <= 1'b0;
      end else if (gateCondition && !condPrev) begin
         inWindow <= 1'b1;
      end
   end

   assign spmWindow = inWindow && gateCondition;
   assign gateValue = gateControlW[GC_SPM] ? spmWindow : gateCondition;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         gateValPrev <= 1'b0;
      end else begin
         gateValPrev <= gateValue;
      end
   end

   // software write of one sets go only when single-pulse is enabled
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         acqGo <= 1'b0;
      end else if (inWindow && !gateCondition) begin
         acqGo <= 1'b0;
      end else if (wrGateControl) begin
         acqGo <= avs_writedata[GC_GO] && avs_writedata[GC_SPM];
      end
   end

   // ---------------- counter ----------------
   always_comb begin
      if (!timerOn) begin
         countEnable = 1'b0;
      end else if (gateControlW[GC_GE]) begin
         countEnable = gateValue;
      end else begin
         countEnable = 1'b1;
      end
   end

   logic countTick;
   assign countTick = countEnable && scaledTick && sleepOk;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         count <= COUNT_RESET;
      end else if (wrCountLow) begin
         count[7:0] <= avs_writedata[7:0];
      end else if (wrCountHigh) begin
         count[15:8] <= avs_writedata[7:0];
      end else if (countTick) begin
         count <= count + 16'h0001;
      end
   end

   logic wrapEvent;
   assign wrapEvent = countTick && (count == COUNT_MAX) && !wrCountLow && !wrCountHigh;

   // flags: a hardware set wins over a software clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         overflowFlag <= 1'b0;
      end else if (wrapEvent) begin
         overflowFlag <= 1'b1;
      end else if (wrFlags) begin
         overflowFlag <= avs_writedata[PE_OVF];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         gateEventFlag <= 1'b0;
      end else if (gateValPrev && !gateValue) begin
         gateEventFlag <= 1'b1;
      end else if (wrFlags) begin
         gateEventFlag <= avs_writedata[PE_GATE];
      end
   end

   // ---------------- control registers ----------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         timerControl <= TC_RESET;
      end else if (wrTimerControl) begin
         timerControl <= avs_writedata[7:0] & TC_WMASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         gateControlW <= GC_RESET;
      end else if (wrGateControl) begin
         gateControlW <= avs_writedata[7:0] & GC_WMASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         periphEnables <= 8'h00;
         intControl    <= 8'h00;
      end else begin
         if (wrPeriph) begin
            periphEnables <= avs_writedata[7:0] & PE_WMASK;
         end
         if (wrInt) begin
            intControl <= avs_writedata[7:0] & IC_WMASK;
         end
      end
   end

   // ---------------- outputs ----------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         overflowIrq  <= 1'b0;
         gateEventIrq <= 1'b0;
         wakeUp       <= 1'b0;
      end else begin
         overflowIrq  <= overflowFlag && timerOn && periphEnables[PE_OVF] &&
                         intControl[IC_PERIPHERAL_INT_ENABLE] && intControl[IC_GIE] && !sleepMode;
         gateEventIrq <= gateEventFlag && periphEnables[PE_GATE] &&
                         intControl[IC_PERIPHERAL_INT_ENABLE] && intControl[IC_GIE];
         // wake needs no global enable; vectoring after wake does
         wakeUp       <= sleepMode && overflowFlag && timerOn &&
                         periphEnables[PE_OVF] && intControl[IC_PERIPHERAL_INT_ENABLE];
      end
   end

   always_comb begin
      gateControlRd         = gateControlW;
      gateControlRd[GC_GO]  = acqGo;
      gateControlRd[GC_VAL] = gateValue;
   end

   always_comb begin
      next_readdata = UNMAPPED_RD;
      unique case (avs_address)
         ADDR_TIMER_CONTROL: next_readdata[7:0] = timerControl;
         ADDR_GATE_CONTROL:  next_readdata[7:0] = gateControlRd;
         ADDR_COUNT_LOW:     next_readdata[7:0] = count[7:0];
         ADDR_COUNT_HIGH:    next_readdata[7:0] = count[15:8];
         ADDR_PERIPH_ENABLE: next_readdata[7:0] = periphEnables;
         ADDR_PERIPH_FLAGS:  next_readdata[7:0] = {gateEventFlag, 6'h00, overflowFlag};
         ADDR_INT_CONTROL:   next_readdata[7:0] = intControl;
         default:            next_readdata = UNMAPPED_RD;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         avs_readdata <= 32'h00000000;
      end else if (reqValid && avs_read) begin
         avs_readdata <= next_readdata;
      end
   end
endmodule

`default_nettype wire

/* File: verification/gtm_pin_model.sv */
// gtm_pin_model: far side of the gated timer, count clock and gate sources
// assumes one bench process calls its tasks just after a rising core_clk edge
`timescale 1ns/10ps
`default_nettype none
module gtm_pin_model (
   input  wire logic                 core_clk,
   output var gtm_pkg::gtm_pins_type pins
);
   import gtm_pkg::*;
   initial pins = '0;
   // two cycles per level so the synchronised edge detect never misses one
   task automatic clkPulses(input int n);
      repeat (2 * n) begin
         @(posedge core_clk);
         pins.externalClockPin <= ~pins.externalClockPin;
         @(posedge core_clk);
      end
   endtask
   // a rise then a fall of the companion source is a single-cycle wrap pulse
   task automatic gateDrive(input logic [1:0] src, input logic lvl);
      @(posedge core_clk);
      case (src)
         GS_COMPANION: begin
            pins.companionTimerWrapPulse <= lvl;
         end
         GS_COMPARATOR: begin
            pins.comparatorOutputSynced <= lvl;
         end
         default: begin
            pins.gatePin <= lvl;
         end
      endcase
   endtask
endmodule
`default_nettype wire

/* File: verification/gtm_timer_asserts.sv */
// gtm_timer_asserts: port-level checks of bus handshake and wake outputs
// assumes single core_clk domain with synchronous active-low rstn
`timescale 1ns/10ps
`default_nettype none
module gtm_timer_asserts (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest,
   input  wire logic        sleepMode,
   input  wire logic        overflowIrq,
   input  wire logic        gateEventIrq,
   input  wire logic        wakeUp
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      && $past(avs_waitrequest) |=> !avs_waitrequest)
      else $error("request not answered in one cycle");
   a_ack_req: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without request");
   a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_unmapped_zero: assert property (!avs_waitrequest && $past(avs_read)
      && $past(avs_address) > 5'h18 |-> avs_readdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_data_holds: assert property ($changed(avs_readdata) |-> !avs_waitrequest && $past(avs_read))
      else $error("read data moved outside a read answer");
   a_reset_idle: assert property ($rose(rstn) |-> avs_waitrequest && !overflowIrq
      && !gateEventIrq && !wakeUp)
      else $error("outputs not idle after reset");
   a_wake_sleep: assert property (wakeUp |-> $past(sleepMode))
      else $error("wake raised while awake");
   a_irq_awake: assert property (overflowIrq |-> !$past(sleepMode))
      else $error("overflow interrupt raised in sleep");
   c_read: cover property (!avs_waitrequest && $past(avs_read));
   c_wake: cover property ($rose(wakeUp));
   c_gate_irq: cover property ($rose(gateEventIrq));
   c_ovf_irq: cover property ($rose(overflowIrq));
endmodule
bind gtm_timer gtm_timer_asserts i_gtm_timer_asserts (
   .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .sleepMode(sleepMode), .overflowIrq(overflowIrq), .gateEventIrq(gateEventIrq),
   .wakeUp(wakeUp)
);
`default_nettype wire

/* File: verification/gated_timer_sixteen_bit_tb.sv */
// gated_timer_sixteen_bit_tb: self-checking bench for gtm_timer over avalon-mm
// assumes gtm_pin_model drives the pins and the checker binds itself in
`timescale 1ns/10ps
`default_nettype none
module gated_timer_sixteen_bit_tb;
   import gtm_pkg::*;
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
   } gtm_row_type;
   localparam gtm_row_type ROWS [8] = '{
      '{ADDR_COUNT_LOW, 8'h5A, 8'h5A}, '{ADDR_COUNT_HIGH, 8'hA5, 8'hA5},
      '{ADDR_PERIPH_ENABLE, 8'hFF, 8'h81}, '{ADDR_INT_CONTROL, 8'hFF, 8'hC0},
      '{ADDR_PERIPH_FLAGS, 8'h81, 8'h81}, '{ADDR_PERIPH_FLAGS, 8'h00, 8'h00},
      '{ADDR_TIMER_CONTROL, 8'hF4, 8'hF4}, '{5'h1C, 8'hFF, 8'h00}};
   logic         core_clk;
   logic         rstn;
   logic [4:0]   avsAddress;
   logic         avsRead;
   logic         avsWrite;
   logic [3:0]   avsByteenable;
   logic [31:0]  avsWritedata;
   logic [31:0]  avsReaddata;
   logic         avsWaitrequest;
   gtm_pins_type pins;
   logic         sleepMode;
   logic         overflowIrq;
   logic         gateEventIrq;
   logic         wakeUp;
   logic [7:0]   d;
   int           badCount;
   int           samplesChecked;
   gtm_timer i_gtm_timer (.core_clk(core_clk), .rstn(rstn), .avs_address(avsAddress),
      .avs_read(avsRead), .avs_write(avsWrite), .avs_byteenable(avsByteenable),
      .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
      .avs_waitrequest(avsWaitrequest), .pins(pins), .sleepMode(sleepMode),
      .overflowIrq(overflowIrq), .gateEventIrq(gateEventIrq), .wakeUp(wakeUp));
   gtm_pin_model i_gtm_pin_model (.core_clk(core_clk), .pins(pins));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic testDone;
      $display("compares %0d mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         badCount++;
      end
   endtask
   // request held until the edge that samples waitrequest low
   task automatic busOp(input logic isWr, input logic [4:0] a, input logic [7:0] wd,
                        output logic [7:0] rd);
      int n;
      n = 0;
      avsAddress   <= a;
      avsWritedata <= {4{wd}};
      avsRead      <= ~isWr;
      avsWrite     <= isWr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avsWaitrequest !== 1'b0 && n < 20);
      rd = avsReaddata[7:0];
      avsRead  <= 1'b0;
      avsWrite <= 1'b0;
      if (avsWaitrequest !== 1'b0) begin
         $display("Error at %0t: bus answer missing", $time);
         badCount++;
         testDone();
      end
      @(posedge core_clk);
   endtask
   task automatic wrReg(input logic [4:0] a, input logic [7:0] wd);
      logic [7:0] dummy;
      busOp(1'b1, a, wd, dummy);
   endtask
   task automatic rdReg(input logic [4:0] a, output logic [7:0] rd);
      busOp(1'b0, a, 8'h00, rd);
   endtask
   task automatic doReset;
      rstn <= 1'b0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
   endtask
   task automatic waitOut(input bit wake);
      int n;
      for (n = 0; n < 100 && (wake ? wakeUp : overflowIrq) !== 1'b1; n++) begin
         @(posedge core_clk);
      end
      if (n == 100) begin
         $display("Error at %0t: interrupt output never rose", $time);
         badCount++;
         testDone();
      end
   endtask
   task automatic zeroCount(input logic [7:0] tc);
      wrReg(ADDR_TIMER_CONTROL, 8'h00);
      wrReg(ADDR_COUNT_HIGH, 8'h00);
      wrReg(ADDR_COUNT_LOW, 8'h00);
      wrReg(ADDR_TIMER_CONTROL, tc);
   endtask
   initial begin
      rstn = 1'b0;
      avsAddress = 5'h00;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsByteenable = 4'h1;
      avsWritedata = 32'h00000000;
      sleepMode = 1'b0;
      badCount = 0;
      samplesChecked = 0;
      doReset();
      foreach (ROWS[i]) begin
         wrReg(ROWS[i].addr, ROWS[i].wdata);
         rdReg(ROWS[i].addr, d);
         chk(d, ROWS[i].rdata);
      end
      // lane 0 disabled: the write must leave the low count byte alone
      avsByteenable <= 4'hE;
      wrReg(ADDR_COUNT_LOW, 8'h11);
      avsByteenable <= 4'hF;
      rdReg(ADDR_COUNT_LOW, d);
      chk(d, 8'h5A);
      doReset();
      for (int a = 0; a < 7; a++) begin
         if (a != 1) begin
            rdReg(5'(a * 4), d);
            chk(d, 8'h00);
         end
      end
      // prescaler cleared by the count write, so each pass starts aligned
      for (int ps = 0; ps < 4; ps++) begin
         zeroCount(8'h81 | 8'(ps << 4));
         i_gtm_pin_model.clkPulses(8);
         rdReg(ADDR_COUNT_LOW, d);
         chk(d, 8'(8 >> ps));
      end
      zeroCount(8'h81);
      wrReg(ADDR_GATE_CONTROL, 8'hC0);
      i_gtm_pin_model.clkPulses(4);
      rdReg(ADDR_COUNT_LOW, d);
      chk(d, 8'h00);
      i_gtm_pin_model.gateDrive(2'd0, 1'b1);
      i_gtm_pin_model.clkPulses(4);
      rdReg(ADDR_COUNT_LOW, d);
      chk(d, 8'h04);
      wrReg(ADDR_GATE_CONTROL, 8'h80);
      i_gtm_pin_model.clkPulses(4);
      rdReg(ADDR_COUNT_LOW, d);
      chk(d, 8'h04);
      wrReg(ADDR_GATE_CONTROL, 8'h40);
      i_gtm_pin_model.clkPulses(4);
      rdReg(ADDR_COUNT_LOW, d);
      chk(d, 8'h08);
      rdReg(ADDR_GATE_CONTROL, d);
      chk(d, 8'h44);
      wrReg(ADDR_PERIPH_ENABLE, 8'h80);
      wrReg(ADDR_INT_CONTROL, 8'hC0);
      i_gtm_pin_model.gateDrive(2'd0, 1'b0);
      // source switched before the flag is cleared: a switch may itself fall
      for (int s = 0; s < 4; s++) begin
         wrReg(ADDR_GATE_CONTROL, 8'h40 | 8'(s));
         wrReg(ADDR_PERIPH_FLAGS, 8'h00);
         i_gtm_pin_model.gateDrive(2'(s), 1'b1);
         i_gtm_pin_model.gateDrive(2'(s), 1'b0);
         repeat (4) @(posedge core_clk);
         rdReg(ADDR_PERIPH_FLAGS, d);
         chk(d & 8'h80, (s == 3) ? 8'h00 : 8'h80);
         chk({7'h00, gateEventIrq}, (s == 3) ? 8'h00 : 8'h01);
      end
      wrReg(ADDR_INT_CONTROL, 8'h00);
      zeroCount(8'h81);
      wrReg(ADDR_GATE_CONTROL, 8'hD0);
      wrReg(ADDR_GATE_CONTROL, 8'hD8);
      rdReg(ADDR_GATE_CONTROL, d);
      chk(d & 8'h08, 8'h08);
      for (int k = 0; k < 2; k++) begin
         i_gtm_pin_model.gateDrive(2'd0, 1'b1);
         i_gtm_pin_model.clkPulses(3);
         i_gtm_pin_model.gateDrive(2'd0, 1'b0);
         i_gtm_pin_model.clkPulses(1);
         rdReg(ADDR_COUNT_LOW, d);
         chk(d, 8'h03);
      end
      rdReg(ADDR_GATE_CONTROL, d);
      chk(d & 8'h08, 8'h00);
      // toggle plus single pulse: rise opens, fall keeps counting, next rise ends it
      wrReg(ADDR_GATE_CONTROL, 8'hF8);
      for (int k = 0; k < 3; k++) begin
         i_gtm_pin_model.gateDrive(2'd0, k != 1);
         i_gtm_pin_model.clkPulses(2);
      end
      rdReg(ADDR_COUNT_LOW, d);
      chk(d, 8'h07);
      rdReg(ADDR_GATE_CONTROL, d);
      chk(d & 8'h08, 8'h00);
      wrReg(ADDR_GATE_CONTROL, 8'h00);
      wrReg(ADDR_PERIPH_FLAGS, 8'h00);
      wrReg(ADDR_PERIPH_ENABLE, 8'h01);
      wrReg(ADDR_INT_CONTROL, 8'hC0);
      wrReg(ADDR_TIMER_CONTROL, 8'h00);
      wrReg(ADDR_COUNT_HIGH, 8'hFF);
      wrReg(ADDR_COUNT_LOW, 8'hFE);
      wrReg(ADDR_TIMER_CONTROL, 8'h41);
      waitOut(1'b0);
      wrReg(ADDR_TIMER_CONTROL, 8'h00);
      chk({7'h00, overflowIrq}, 8'h00);
      rdReg(ADDR_PERIPH_FLAGS, d);
      chk(d & 8'h01, 8'h01);
      rdReg(ADDR_COUNT_HIGH, d);
      chk(d, 8'h00);
      wrReg(ADDR_PERIPH_FLAGS, 8'h00);
      wrReg(ADDR_INT_CONTROL, 8'h40);
      wrReg(ADDR_COUNT_HIGH, 8'hFF);
      wrReg(ADDR_COUNT_LOW, 8'hFF);
      sleepMode <= 1'b1;
      wrReg(ADDR_TIMER_CONTROL, 8'h85);
      i_gtm_pin_model.clkPulses(1);
      waitOut(1'b1);
      chk({7'h00, wakeUp}, 8'h01);
      chk({7'h00, overflowIrq}, 8'h00);
      sleepMode <= 1'b0;
      testDone();
   end
endmodule
`default_nettype wire
